// *** src/embedded_flash_controller.sv ***
// embedded flash controller: ahb-lite slave over a flash plane model,
// page latch buffer, wait-state reads with fetch prefetch, and the
// key-protected command sequencer with lock and nvm bits.
// assumes a single ahb-lite master, hprot[0] low marks an opcode fetch.
`timescale 1ns/100ps
`default_nettype none

module embedded_flash_controller #(
	parameter int LOCK_BITS   = 16,
	parameter int PROG_CYCLES = 100000,
	parameter int WIPE_CYCLES = 200000,
	parameter int BIT_CYCLES  = 1000
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [3:0]  hprot,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic [31:0] hrdata,
	// interrupt
	output var  logic        irq
);

	// ------------------------------------------------------------
	// derived constants
	// ------------------------------------------------------------
	localparam int          NPAGES = 1 << flash_ctrl_pkg::PAGE_NW;
	localparam int          RSHIFT = $clog2(NPAGES / LOCK_BITS);
	localparam logic [31:0] LMASK  = 32'((64'h1 << LOCK_BITS) - 64'h1);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	flash_ctrl_pkg::ctrl_t s;
	flash_ctrl_pkg::ctrl_t n;
	logic [31:0] flash_mem [0:(1 << flash_ctrl_pkg::FLASH_AW)-1];
	logic [31:0] latch_mem [0:(1 << flash_ctrl_pkg::PAGE_AW)-1];

	logic [flash_ctrl_pkg::FLASH_AW-1:0] a_word;
	logic [flash_ctrl_pkg::FLASH_AW-1:0] fl_wa;
	logic [31:0]                         fl_wd;
	logic [31:0]                         rd_a;
	logic [31:0]                         rd_b;
	logic [31:0]                         rd_c;
	logic [31:0]                         lt_rd;
	logic                                fl_we;
	logic                                lt_we;
	logic                                lt_clr;
	logic                                acc;
	logic                                fetch;
	logic [1:0]                          fetch_wait_states;
	logic                                dp_end;
	logic                                cmd_wr;
	logic [7:0]                          key;
	logic [3:0]                          code;
	logic [flash_ctrl_pkg::PAGE_NW-1:0]  pg;
	logic [4:0]                          region;
	logic                                code_ok;
	logic                                any_lock;

	// only the flash-sized bits pick a word, so the image repeats
	assign a_word = haddr[flash_ctrl_pkg::FLASH_AW+1:2];
	assign acc    = hsel & htrans[1] & hready;
	assign fetch  = ~hprot[0];
	assign fetch_wait_states = s.mode[flash_ctrl_pkg::WAIT_LSB +: 2];
	assign dp_end = s.dp.valid & s.hreadyout;
	assign cmd_wr = dp_end & s.dp.write & s.dp.is_reg
		& (s.dp.off == flash_ctrl_pkg::CMD_OFF);
	assign key    = hwdata[flash_ctrl_pkg::KEY_LSB +: 8];
	assign code   = hwdata[3:0];
	assign pg     = hwdata[flash_ctrl_pkg::PAGE_LSB +: flash_ctrl_pkg::PAGE_NW];
	assign region = 5'(pg >> RSHIFT);
	assign any_lock = |(~s.lock_n & LMASK);

	// valid command codes; anything else is a programming error
	always_comb begin
		case (code)
		flash_ctrl_pkg::WRITE_PAGE_CMD,
		flash_ctrl_pkg::SET_LOCK_CMD,
		flash_ctrl_pkg::WRITE_PAGE_LOCK_CMD,
		flash_ctrl_pkg::UNLOCK_REGION_CMD: code_ok = 1'b1;
		flash_ctrl_pkg::FULL_WIPE_CMD,
		flash_ctrl_pkg::SET_NVM_BIT_CMD,
		flash_ctrl_pkg::RESET_NVM_BIT_CMD,
		flash_ctrl_pkg::SET_SECURITY_CMD: code_ok = 1'b1;
		default: code_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// memory ports
	// ------------------------------------------------------------
	// the page walk writes one word a cycle and sets each latch word back to ones
	assign fl_we  = (s.cstate == flash_ctrl_pkg::CS_PROG)
		| (s.cstate == flash_ctrl_pkg::CS_WIPE);
	assign fl_wa  = (s.cstate == flash_ctrl_pkg::CS_PROG)
		? {s.op_page, s.idx[flash_ctrl_pkg::PAGE_AW-1:0]} : s.idx;
	assign rd_a   = flash_mem[a_word];
	assign rd_b   = flash_mem[s.dp.word];
	assign rd_c   = flash_mem[fl_wa];
	assign lt_rd  = latch_mem[s.idx[flash_ctrl_pkg::PAGE_AW-1:0]];
	assign lt_clr = (s.cstate == flash_ctrl_pkg::CS_PROG);
	assign lt_we  = dp_end & s.dp.write & ~s.dp.is_reg;

	// erase-then-program gives the latch word; without erase, bits
	// can only be cleared, so old and new are and-ed
	always_comb begin
		if (s.cstate == flash_ctrl_pkg::CS_WIPE) begin
			fl_wd = 32'hffff_ffff;
		end else if (s.op_no_erase) begin
			fl_wd = rd_c & lt_rd;
		end else begin
			fl_wd = lt_rd;
		end
	end

	// arrays carry no reset; a wipe command brings flash to ones
	always_ff @(posedge clk) begin
		if (fl_we) begin
			flash_mem[fl_wa] <= fl_wd;
		end
		if (lt_clr) begin
			latch_mem[s.idx[flash_ctrl_pkg::PAGE_AW-1:0]] <= 32'hffff_ffff;
		end else if (lt_we) begin
			// only bits 7:2 select the word: latch repeats everywhere
			latch_mem[s.dp.word[flash_ctrl_pkg::PAGE_AW-1:0]] <= hwdata;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = s;
		n.hresp = 1'b0;
		n.irq   = s.mode[flash_ctrl_pkg::RDY_IE_BIT] & s.ready;

		// data phase in progress: count wait states down
		if (s.dp.valid & ~s.hreadyout) begin
			n.wait_cnt = s.wait_cnt - 2'h1;
			if (s.wait_cnt == 2'h1) begin
				n.hreadyout = 1'b1;
				n.hrdata    = s.dp.write ? 32'h0 : rd_b;
			end
		end
		if (dp_end) begin
			n.dp.valid = 1'b0;
			if (s.dp.write & s.dp.is_reg
				& (s.dp.off == flash_ctrl_pkg::MODE_OFF)) begin
				n.mode = hwdata & flash_ctrl_pkg::MODE_MASK;
			end
		end

		// address phase: decode, pick wait states, prepare read data
		if (acc) begin
			n.dp.valid  = 1'b1;
			n.dp.write  = hwrite;
			n.dp.is_reg = haddr[flash_ctrl_pkg::REG_SEL_BIT];
			n.dp.off    = haddr[7:0];
			n.dp.word   = a_word;
			n.wait_cnt  = 2'h0;
			n.hrdata    = 32'h0;
			if (haddr[flash_ctrl_pkg::REG_SEL_BIT]) begin
				if (!hwrite) begin
					case (haddr[7:0])
					flash_ctrl_pkg::MODE_OFF: n.hrdata = s.mode;
					flash_ctrl_pkg::STAT_OFF: begin
						n.hrdata[flash_ctrl_pkg::ST_RDY_BIT] = s.ready;
						n.hrdata[flash_ctrl_pkg::ST_LOCK_ERR] = s.lock_err;
						n.hrdata[flash_ctrl_pkg::ST_PROG_ERR] = s.prog_err;
						n.hrdata[flash_ctrl_pkg::ST_SEC]     = s.security;
						n.hrdata[flash_ctrl_pkg::ST_NVM_LSB +: 2] = ~s.nvm_n;
						// reading status clears both error flags
						n.prog_err = 1'b0;
						n.lock_err = 1'b0;
					end
					flash_ctrl_pkg::LOCK_OFF: n.hrdata = ~s.lock_n & LMASK;
					default: n.hrdata = 32'h0;
					endcase
				end
			end else if (hwrite) begin
				// writes cost one more than reads, capped at three
				n.wait_cnt = (fetch_wait_states == flash_ctrl_pkg::MAX_WS)
					? flash_ctrl_pkg::MAX_WS
					: fetch_wait_states + 2'h1;
			end else if (fetch) begin
				if (s.buf_valid && a_word == s.buf_word) begin
					// second read of a pair: launch the next word
					n.pf_valid = 1'b1;
				end else if (s.pf_valid
					&& a_word == s.buf_word + 12'h1) begin
					// prefetch hides one wait state, not two or three
					n.wait_cnt  = (fetch_wait_states < 2'h2)
						? 2'h0 : fetch_wait_states;
					n.buf_word  = a_word;
					n.pf_valid  = 1'b0;
				end else begin
					n.wait_cnt  = fetch_wait_states;
					n.buf_word  = a_word;
					n.buf_valid = 1'b1;
					n.pf_valid  = 1'b0;
				end
			end else begin
				// data reads leave both buffers alone
				n.wait_cnt = fetch_wait_states;
			end
			// full word is returned; the master picks its lanes
			if (n.wait_cnt == 2'h0) begin
				n.hreadyout = 1'b1;
				if (!hwrite && !haddr[flash_ctrl_pkg::REG_SEL_BIT]) begin
					n.hrdata = rd_a;
				end
			end else begin
				n.hreadyout = 1'b0;
			end
		end

		// command sequencer
		case (s.cstate)
		flash_ctrl_pkg::CS_IDLE: begin
			// a write while busy is dropped, never queued
			if (cmd_wr && s.ready) begin
				n.ready   = 1'b0;
				n.op_code = code;
				n.op_page = pg;
				n.op_no_erase = s.mode[flash_ctrl_pkg::NOERASE_BIT];
				n.idx     = '0;
				n.timer   = 20'h0;
				n.cstate  = flash_ctrl_pkg::CS_HOLD;
				if (key != flash_ctrl_pkg::CMD_KEY || !code_ok) begin
					n.prog_err = 1'b1;
				end else begin
					case (code)
					flash_ctrl_pkg::WRITE_PAGE_CMD,
					flash_ctrl_pkg::WRITE_PAGE_LOCK_CMD: begin
						if (!s.lock_n[region]) begin
							n.lock_err = 1'b1;
						end else begin
							n.cstate = flash_ctrl_pkg::CS_PROG;
						end
					end
					flash_ctrl_pkg::FULL_WIPE_CMD: begin
						if (any_lock) begin
							n.lock_err = 1'b1;
						end else begin
							n.cstate = flash_ctrl_pkg::CS_WIPE;
						end
					end
					flash_ctrl_pkg::SET_LOCK_CMD: begin
						n.lock_n[region] = 1'b0;
						n.timer = 20'(BIT_CYCLES);
					end
					flash_ctrl_pkg::UNLOCK_REGION_CMD: begin
						n.lock_n[region] = 1'b1;
						n.timer = 20'(BIT_CYCLES);
					end
					flash_ctrl_pkg::SET_NVM_BIT_CMD: begin
						// numbers past the last nvm bit do nothing
						if (32'(pg) < flash_ctrl_pkg::NVM_BITS) begin
							n.nvm_n[pg[0]] = 1'b0;
						end
						n.timer = 20'(BIT_CYCLES);
					end
					flash_ctrl_pkg::RESET_NVM_BIT_CMD: begin
						if (32'(pg) < flash_ctrl_pkg::NVM_BITS) begin
							n.nvm_n[pg[0]] = 1'b1;
						end
						n.timer = 20'(BIT_CYCLES);
					end
					default: begin
						n.security = 1'b1;
						n.timer = 20'(BIT_CYCLES);
					end
					endcase
				end
			end
		end
		flash_ctrl_pkg::CS_PROG: begin
			n.idx = s.idx + 12'h1;
			if (s.idx[flash_ctrl_pkg::PAGE_AW-1:0] == '1) begin
				if (s.op_code == flash_ctrl_pkg::WRITE_PAGE_LOCK_CMD) begin
					n.lock_n[5'(s.op_page >> RSHIFT)] = 1'b0;
				end
				n.buf_valid = 1'b0;
				n.pf_valid  = 1'b0;
				n.timer     = 20'(PROG_CYCLES);
				n.cstate    = flash_ctrl_pkg::CS_HOLD;
			end
		end
		flash_ctrl_pkg::CS_WIPE: begin
			n.idx = s.idx + 12'h1;
			if (s.idx == '1) begin
				n.buf_valid = 1'b0;
				n.pf_valid  = 1'b0;
				n.timer     = 20'(WIPE_CYCLES);
				n.cstate    = flash_ctrl_pkg::CS_HOLD;
			end
		end
		flash_ctrl_pkg::CS_HOLD: begin
			if (s.timer == 20'h0) begin
				n.ready  = 1'b1;
				n.cstate = flash_ctrl_pkg::CS_IDLE;
			end else begin
				n.timer = s.timer - 20'h1;
			end
		end
		default: n.cstate = flash_ctrl_pkg::CS_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s           <= '0;
			s.hreadyout <= 1'b1;
			s.mode      <= flash_ctrl_pkg::MODE_RST;
			s.ready     <= 1'b1;
			s.nvm_n     <= '1;
			s.lock_n    <= '1;
			s.cstate    <= flash_ctrl_pkg::CS_IDLE;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hresp     = s.hresp;
	assign hrdata    = s.hrdata;
	assign irq       = s.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_rd_ws0;
		@(posedge clk) disable iff (rst)
		acc && !hwrite && !haddr[flash_ctrl_pkg::REG_SEL_BIT]
		&& fetch_wait_states == 2'h0 |=> hreadyout;
	endproperty
	a_rd_ws0: assert property (p_rd_ws0)
		else $error("zero-wait read stalled");

	property p_rd_ws3;
		@(posedge clk) disable iff (rst)
		acc && !hwrite && !fetch && !haddr[flash_ctrl_pkg::REG_SEL_BIT]
		&& fetch_wait_states == 2'h3 |=> !hreadyout [*3] ##1 hreadyout;
	endproperty
	a_rd_ws3: assert property (p_rd_ws3)
		else $error("data read not three waits");

	property p_wr_ws1;
		@(posedge clk) disable iff (rst)
		acc && hwrite && !haddr[flash_ctrl_pkg::REG_SEL_BIT]
		&& fetch_wait_states == 2'h1 |=> !hreadyout [*2] ##1 hreadyout;
	endproperty
	a_wr_ws1: assert property (p_wr_ws1)
		else $error("write not two waits");

	property p_wr_ws3;
		@(posedge clk) disable iff (rst)
		acc && hwrite && !haddr[flash_ctrl_pkg::REG_SEL_BIT]
		&& fetch_wait_states == 2'h3 |=> !hreadyout [*3] ##1 hreadyout;
	endproperty
	a_wr_ws3: assert property (p_wr_ws3)
		else $error("write wait not saturated");

	property p_pf_ws1;
		@(posedge clk) disable iff (rst)
		acc && !hwrite && fetch && !haddr[flash_ctrl_pkg::REG_SEL_BIT]
		&& fetch_wait_states == 2'h1 && s.pf_valid
		&& a_word == s.buf_word + 12'h1 |=> hreadyout;
	endproperty
	a_pf_ws1: assert property (p_pf_ws1)
		else $error("prefetched fetch waited");

	// the end of a page or wipe walk may drop the buffers on its own
	property p_data_no_pf;
		@(posedge clk) disable iff (rst)
		acc && !hwrite && !fetch && !fl_we
		|=> s.pf_valid == $past(s.pf_valid);
	endproperty
	a_data_no_pf: assert property (p_data_no_pf)
		else $error("data read moved prefetch");

	property p_cmd_busy;
		@(posedge clk) disable iff (rst)
		cmd_wr && s.ready |=> !s.ready;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy)
		else $error("ready not cleared");

	property p_bad_key;
		@(posedge clk) disable iff (rst)
		cmd_wr && s.ready && key != flash_ctrl_pkg::CMD_KEY
		|=> s.prog_err && !fl_we ##1 s.ready;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("bad key not flagged");

	property p_wipe_locked;
		@(posedge clk) disable iff (rst)
		cmd_wr && s.ready && key == flash_ctrl_pkg::CMD_KEY
		&& code == flash_ctrl_pkg::FULL_WIPE_CMD && any_lock
		|=> s.lock_err && s.cstate == flash_ctrl_pkg::CS_HOLD;
	endproperty
	a_wipe_locked: assert property (p_wipe_locked)
		else $error("locked wipe ran");

	property p_busy_drop;
		@(posedge clk) disable iff (rst)
		cmd_wr && !s.ready |=> s.op_code == $past(s.op_code);
	endproperty
	a_busy_drop: assert property (p_busy_drop)
		else $error("busy command taken");

	property p_irq;
		@(posedge clk) disable iff (rst)
		s.ready && s.mode[flash_ctrl_pkg::RDY_IE_BIT] |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("ready interrupt missing");

endmodule

`default_nettype wire

// *** src/flash_ctrl_pkg.sv ***
// package for the embedded flash controller: register map, fields,
// command codes, reset values and the state carriers.
// assumes one 25 MHz clock and an ahb-lite master on the register side.
//
// Behaviour
// - two word buffers let fetch prefetch next word
// - data reads never use or start prefetch
// - read wait states zero to three, programmable
// - zero wait states: every read one cycle
// - one wait state: only first sequential read waits
// - two or three: sequential reads alternate wait/none
// - byte, half-word and word reads all served
// - reads decode only flash-sized address bits
// - latch writes use eight low address bits
// - write-only page-sized latch buffer, any address
// - writes wait one more than reads, at most three
// - codes 01 page, 02 lock, 03 both, 04 unlock
// - codes 08 wipe, 0b/0d nvm set/clear, 0f security
// - command write clears ready; completion sets it
// - ready with enable drives interrupt output
// - key in top byte checked before acting
// - bad key or code: program error, read clears
// - locked page write: lock error, read clears
// - full wipe refused if any region locked
// - erase bit clear: page erased before program
// - erase bit set: program without erase
// - one lock bit per region; 32, 16 or 8
// - two general nvm bits, set and cleared
// - lock stores zero, status shows one
`default_nettype none

package flash_ctrl_pkg;

	// ------------------------------------------------------------
	// geometry and address decode
	// ------------------------------------------------------------
	localparam int          FLASH_AW    = 12; // word address bits
	localparam int          PAGE_AW     = 6;  // words per page, log2
	localparam int          PAGE_NW     = 6;  // page number bits
	localparam int          REG_SEL_BIT = 20; // above 1 mbyte window
	localparam int          NVM_BITS    = 2;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  MODE_OFF    = 8'h00;
	localparam logic [7:0]  CMD_OFF     = 8'h04;
	localparam logic [7:0]  STAT_OFF    = 8'h08;
	localparam logic [7:0]  LOCK_OFF    = 8'h0c;

	// ------------------------------------------------------------
	// fields
	// ------------------------------------------------------------
	localparam int          RDY_IE_BIT  = 0;
	localparam int          NOERASE_BIT = 7;
	localparam int          WAIT_LSB    = 8;
	localparam int          MCC_LSB     = 16;
	localparam logic [31:0] MODE_MASK   = 32'h00ff_0381;
	localparam logic [31:0] MODE_RST    = 32'h0000_0000;
	localparam int          KEY_LSB     = 24;
	localparam int          PAGE_LSB    = 8;
	localparam logic [7:0]  CMD_KEY     = 8'h5a;
	localparam int          ST_RDY_BIT  = 0;
	localparam int          ST_LOCK_ERR = 2;
	localparam int          ST_PROG_ERR = 3;
	localparam int          ST_SEC      = 4;
	localparam int          ST_NVM_LSB  = 8;
	localparam logic [1:0]  MAX_WS      = 2'h3;

	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [3:0]  WRITE_PAGE_CMD      = 4'h1;
	localparam logic [3:0]  SET_LOCK_CMD        = 4'h2;
	localparam logic [3:0]  WRITE_PAGE_LOCK_CMD = 4'h3;
	localparam logic [3:0]  UNLOCK_REGION_CMD   = 4'h4;
	localparam logic [3:0]  FULL_WIPE_CMD       = 4'h8;
	localparam logic [3:0]  SET_NVM_BIT_CMD     = 4'hb;
	localparam logic [3:0]  RESET_NVM_BIT_CMD   = 4'hd;
	localparam logic [3:0]  SET_SECURITY_CMD    = 4'hf;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CS_IDLE, CS_PROG, CS_WIPE, CS_HOLD} cmd_state_t;

	typedef struct packed {
		logic                valid;
		logic                write;
		logic                is_reg;
		logic [7:0]          off;
		logic [FLASH_AW-1:0] word;
	} dphase_t;

	typedef struct packed {
		dphase_t             dp;
		logic [1:0]          wait_cnt;
		logic                hreadyout;
		logic                hresp;
		logic [31:0]         hrdata;
		logic                irq;
		logic [31:0]         mode;
		logic                ready;
		logic                prog_err;
		logic                lock_err;
		logic                security;
		logic [1:0]          nvm_n;
		logic [31:0]         lock_n;
		logic [FLASH_AW-1:0] buf_word;
		logic                buf_valid;
		logic                pf_valid;
		cmd_state_t          cstate;
		logic [3:0]          op_code;
		logic [PAGE_NW-1:0]  op_page;
		logic                op_no_erase;
		logic [FLASH_AW-1:0] idx;
		logic [19:0]         timer;
	} ctrl_t;

endpackage

`default_nettype wire

// *** verif/ahb_master_model.sv ***
// bus master model: single ahb-lite word transfers for the bench.
// assumes one slave whose hreadyout is the bus hready.
`timescale 1ns/100ps
`default_nettype none

module ahb_master_model (
	// clock and bus return
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// request side
	output var  logic        hsel,
	output var  logic [31:0] haddr,
	output var  logic [1:0]  htrans,
	output var  logic        hwrite,
	output var  logic [2:0]  hsize,
	output var  logic [3:0]  hprot,
	output var  logic [31:0] hwdata
);
	// idle bus at time zero
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hprot  = 4'h1;
		hwdata = 32'h0;
	end

	// ------------------------------------------------------------
	// one transfer, entered right after a rising edge
	// ------------------------------------------------------------
	// waits is -1 when the slave never answers
	task automatic xfer(input logic wr, input logic [31:0] a, wd,
			input logic [3:0] pr, output logic [31:0] rd, output int waits);
		int n;
		n = 0;
		waits = 0;
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		hprot  <= pr;
		@(posedge clk);
		while (hready !== 1'b1 && n < 9000) begin
			n++;
			@(posedge clk);
		end
		// released address lines show the inverse, not stale values
		htrans <= 2'h0;
		hsel   <= 1'b0;
		haddr  <= ~a;
		hwdata <= wd;
		@(posedge clk);
		while (hready !== 1'b1 && n < 9000) begin
			n++;
			waits++;
			@(posedge clk);
		end
		rd = hrdata;
		hwdata <= ~wd;
		if (n >= 9000)
			waits = -1;
	endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the embedded flash controller.
// assumes the master model is the only bus master.
`timescale 1ns/100ps
`default_nettype none

module tb;
	logic        clk;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [3:0]  hprot;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic [31:0] rd;
	logic [31:0] acc;
	int          w;
	int          mismatches = 0;
	int          cmp_count = 0;
	// microsecond count set before any command
	localparam logic [31:0] MODE = 32'h0019_0000;

	// short timings keep the run small
	embedded_flash_controller #(.PROG_CYCLES(20), .WIPE_CYCLES(20),
			.BIT_CYCLES(5)) dut_u (.clk(clk), .rst(rst), .hsel(hsel),
			.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
			.hprot(hprot), .hwdata(hwdata), .hready(hreadyout),
			.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));
	ahb_master_model mst_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
			.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
			.hsize(hsize), .hprot(hprot), .hwdata(hwdata));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] fa(input int pg, input int i);
		return {18'h0, pg[5:0], i[5:0], 2'h0};
	endfunction

	task automatic bus(input logic wr, input logic [31:0] a, wd,
			input logic [3:0] pr);
		mst_u.xfer(wr, a, wd, pr, rd, w);
		if (w < 0) begin
			mismatches++;
			report_and_stop();
		end
	endtask

	task automatic rreg(input logic [7:0] off);
		bus(1'b0, {24'h00_1000, off}, 32'h0, 4'h1);
	endtask

	// command write, then poll status; acc gathers the flags seen
	task automatic cmd(input logic [7:0] key, input logic [3:0] code,
			input logic [5:0] pg);
		bus(1'b1, 32'h0010_0004, {key, 10'h0, pg, 4'h0, code}, 4'h1);
		acc = 32'h0;
		for (int i = 0; i < 9000; i++) begin
			rreg(8'h08);
			acc |= rd;
			if (rd[0] === 1'b1)
				return;
		end
		mismatches++;
		report_and_stop();
	endtask

	typedef struct packed {
		logic [7:0]  off;
		logic [31:0] wd;
		logic [31:0] exp;
	} row_t;
	row_t rows [4] = '{'{8'h00, 32'hffff_ffff, 32'h00ff_0381},
		'{8'h00, 32'h0000_0000, 32'h0}, '{8'h10, 32'hffff_ffff, 32'h0},
		'{8'h0c, 32'hffff_ffff, 32'h0}};

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[k]) begin
			bus(1'b1, {24'h00_1000, rows[k].off}, rows[k].wd, 4'h1);
			rreg(rows[k].off);
			chk(rd, rows[k].exp);
			chk({31'h0, hresp}, 32'h0);
		end
		// mid-run reset: a dirty mode register must return to rest
		bus(1'b1, 32'h0010_0000, 32'hffff_ffff, 4'h1);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rreg(8'h00);
		chk(rd, 32'h0);
		rreg(8'h08);
		chk(rd, 32'h1);
		// wait states per setting; own page per setting avoids stale hits
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, 32'h0010_0000, MODE | {22'h0, f[1:0], 8'h0}, 4'h1);
			bus(1'b0, fa(f, 0), 32'h0, 4'h1);
			chk(w, f);
			bus(1'b1, fa(f, 1), 32'h0, 4'h1);
			chk(w, f == 3 ? 3 : f + 1);
			bus(1'b0, fa(f, 8), 32'h0, 4'h0);
			chk(w, f);
			bus(1'b0, fa(f, 8), 32'h0, 4'h0);
			chk(w, 0);
			bus(1'b0, fa(f, 9), 32'h0, 4'h0);
			chk(w, f < 2 ? 0 : f);
			bus(1'b0, fa(f, 10), 32'h0, 4'h1);
			chk(w, f);
		end
		bus(1'b1, 32'h0010_0000, MODE | 32'h1, 4'h1);
		cmd(8'h5a, 4'h8, 6'h0);
		chk(acc & 32'hc, 32'h0);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		// latch filled through an aliased address, read through another
		for (int i = 0; i < 4; i++)
			bus(1'b1, 32'h0003_1f00 + 4 * i, 32'ha5a5_0000 + i, 4'h1);
		cmd(8'h5a, 4'h1, 6'h2);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 32'h0000_4200 + 4 * i, 32'h0, 4'h1);
			chk(rd, 32'ha5a5_0000 + i);
		end
		bus(1'b1, 32'h0010_0000, MODE | 32'h81, 4'h1);
		bus(1'b1, fa(0, 0), 32'h0f0f_ffff, 4'h1);
		cmd(8'h5a, 4'h1, 6'h2);
		bus(1'b0, fa(2, 0), 32'h0, 4'h1);
		chk(rd, 32'h0505_0000);
		bus(1'b1, 32'h0010_0000, MODE | 32'h1, 4'h1);
		bus(1'b1, fa(0, 0), 32'h1234_5678, 4'h1);
		cmd(8'h5a, 4'h1, 6'h2);
		bus(1'b0, fa(2, 0), 32'h0, 4'h1);
		chk(rd, 32'h1234_5678);
		cmd(8'h5a, 4'h2, 6'h2);
		rreg(8'h0c);
		chk(rd, 32'h1);
		bus(1'b1, fa(0, 0), 32'h0, 4'h1);
		cmd(8'h5a, 4'h1, 6'h2);
		chk(acc & 32'hc, 32'h4);
		cmd(8'h5a, 4'h8, 6'h0);
		chk(acc & 32'hc, 32'h4);
		bus(1'b0, fa(2, 0), 32'h0, 4'h1);
		chk(rd, 32'h1234_5678);
		cmd(8'h5a, 4'h4, 6'h2);
		cmd(8'h5a, 4'h3, 6'h6);
		rreg(8'h0c);
		chk(rd, 32'h2);
		cmd(8'h5a, 4'h4, 6'h6);
		// bad key, then an unused code
		for (int i = 0; i < 2; i++) begin
			cmd(i ? 8'h5a : 8'h00, i ? 4'h5 : 4'h1, 6'h0);
			chk(acc & 32'hc, 32'h8);
			rreg(8'h08);
			chk(rd & 32'hd, 32'h1);
		end
		cmd(8'h5a, 4'hb, 6'h1);
		chk(rd & 32'h300, 32'h200);
		cmd(8'h5a, 4'hd, 6'h1);
		chk(rd & 32'h300, 32'h0);
		cmd(8'h5a, 4'hf, 6'h0);
		chk(rd & 32'h10, 32'h10);
		// second command while busy must be dropped
		bus(1'b1, 32'h0010_0004, 32'h5a00_0201, 4'h1);
		rreg(8'h08);
		chk(rd & 32'h1, 32'h0);
		chk({31'h0, irq}, 32'h0);
		cmd(8'h5a, 4'h2, 6'h2);
		rreg(8'h0c);
		chk(rd, 32'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
